// File: hdl/bcpm_consts.vh
// Constants for the battery charge port manager: offsets, fields, resets, timing.
// Assumes a 25 MHz mclk and a 32-bit AXI4-Lite register bus.
//
// Functional notes
// - Detection enabled: entering the charger-detect stage starts upstream detection automatically.
// - Shorted data pair is reported as dedicated charging port, code 001.
// - DP reflected onto DM reports code 010, only with enhanced flag set.
// - Pull-downs on both data lines report standard downstream port, code 011.
// - Vendor level profiles report 100 low, 101 high, 110 super high current.
// - Known charger type raises interrupt output and stays readable in status.
// - Optionally run detection during wait-reference-clock stage on internal oscillator.
// - No upstream detection while upstream port is an inter-chip link.
// - Charging enable bit n maps to port n from bit 1; asserts power.
// - Inter-chip downstream ports never become charging ports.
// - Charging port acts as CDP with host, DCP without; others standard.
// - Port classification is frozen after initialization completes.
// - Charging port power rises after init and drops on over-current.
// - Ganged mode drops every port; individual mode drops only faulty port.
// - DCP over-current: off one second, re-enable, three attempts in total.
// - After three attempts retry forever with ten second off interval.
// - CDP and standard ports leave power and over-current to the host; here their power still drops while overcurrentSense is high.
// - SMBus enabled when both lines pulled up; disabled when data low.
// - SMBus gives external master access to run-time registers; here no SMBus slave is built, smbusEnable only shows in status and on its output pin.
`ifndef BCPM_CONSTS_VH
`define BCPM_CONSTS_VH

`define BCPM_CLK_HZ          25000000
`define BCPM_RETRY_SHORT_MS  1000
`define BCPM_RETRY_LONG_MS   10000
`define BCPM_SETTLE_US       100
`define BCPM_SHORT_RETRIES   3

`define BCPM_OFS_CTRL        8'h00
`define BCPM_OFS_CHGEN       8'h04
`define BCPM_OFS_CHGSTAT     8'h08
`define BCPM_OFS_PORTSTAT    8'h0C

`define BCPM_CTRL_DETEN      0
`define BCPM_CTRL_ENHANCED   1
`define BCPM_CTRL_OSCDET     2
`define BCPM_CTRL_GANGED     3
`define BCPM_CTRL_RESET      4'h0
`define BCPM_CHGEN_RESET     4'h0

`define BCPM_STAT_TYPE_LSB   0
`define BCPM_STAT_VALID      3
`define BCPM_STAT_IRQ        4
`define BCPM_STAT_BUSY       5
`define BCPM_STAT_SMBUS      6

`define BCPM_TYPE_NONE       3'h0
`define BCPM_TYPE_DCP        3'h1
`define BCPM_TYPE_CDP        3'h2
`define BCPM_TYPE_SDP        3'h3
`define BCPM_TYPE_LOW        3'h4
`define BCPM_TYPE_HIGH       3'h5
`define BCPM_TYPE_SUPER      3'h6

`define BCPM_LVL_LOW         2'h0
`define BCPM_LVL_2V0         2'h1
`define BCPM_LVL_2V7         2'h2

`endif

// File: hdl/bcpm_top.v
// Battery charge port manager: upstream charger detection, downstream port power
// and over-current retry, AXI4-Lite register slave.
// Assumes analog comparator results and hub stage flags arrive synchronous to mclk.
//
// Our own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "bcpm_consts.vh"

module bcpm_top #(
  parameter NPORT        = 4,
  parameter TW           = 28,
  parameter [TW-1:0] SHORT_CYCLES  = `BCPM_RETRY_SHORT_MS * (`BCPM_CLK_HZ / 1000),
  parameter [TW-1:0] LONG_CYCLES   = `BCPM_RETRY_LONG_MS * (`BCPM_CLK_HZ / 1000),
  parameter [TW-1:0] SETTLE_CYCLES = `BCPM_SETTLE_US * (`BCPM_CLK_HZ / 1000000)
) (
  // Clock, reset, enable
  input  wire             mclk,
  input  wire             reset,
  input  wire             clkEn,
  // AXI4-Lite slave
  input  wire [7:0]       s_axi_awaddr,
  input  wire             s_axi_awvalid,
  output wire             s_axi_awready,
  input  wire [31:0]      s_axi_wdata,
  input  wire [3:0]       s_axi_wstrb,
  input  wire             s_axi_wvalid,
  output wire             s_axi_wready,
  output reg  [1:0]       s_axi_bresp,
  output reg              s_axi_bvalid,
  input  wire             s_axi_bready,
  input  wire [7:0]       s_axi_araddr,
  input  wire             s_axi_arvalid,
  output wire             s_axi_arready,
  output reg  [31:0]      s_axi_rdata,
  output reg  [1:0]       s_axi_rresp,
  output reg              s_axi_rvalid,
  input  wire             s_axi_rready,
  // Hub start-up flow
  input  wire             chargerDetectStage,
  input  wire             waitReferenceClockStage,
  input  wire             hwInitDone,
  input  wire             upstreamHsic,
  input  wire [NPORT:1]   downstreamHsic,
  input  wire             hostConnected,
  // Upstream line comparators
  input  wire             dpDmShorted,
  input  wire             dmReflectsDp,
  input  wire             bothPulledDown,
  input  wire [1:0]       dpLevel,
  input  wire [1:0]       dmLevel,
  // Downstream power
  input  wire [NPORT:1]   hostPortPowerReq,
  input  wire [NPORT:1]   overcurrentSense,
  output reg  [NPORT:1]   portPowerOut,
  // Status pins
  output reg              chargerIrq,
  output reg              detectBusy,
  output reg              smbusEnable,
  input  wire             smbusDataLine,
  input  wire             smbusClockLine
);

  localparam DET_IDLE   = 2'd0;
  localparam DET_SETTLE = 2'd1;
  localparam DET_CLASS  = 2'd2;

  localparam OC_ON  = 1'b0;
  localparam OC_OFF = 1'b1;

  localparam [1:0] RESP_OK  = 2'b00;
  localparam [1:0] RESP_ERR = 2'b10;
  localparam [1:0] MAXRETRY = `BCPM_SHORT_RETRIES;

  // Configuration and status
  reg  [3:0]      ctrl;
  reg  [NPORT:1]  chgEnable;
  reg  [NPORT:1]  chgClass;
  reg             classFrozen;
  reg  [2:0]      chgType;
  reg             typeValid;
  reg             strapDone;

  // Detector
  reg  [1:0]      detState;
  reg  [TW-1:0]   detTimer;
  reg             prevDetStage;
  reg             prevWaitStage;

  // Over-current retry per port
  reg             ocState  [1:NPORT];
  reg  [TW-1:0]   ocTimer  [1:NPORT];
  reg  [1:0]      retryCnt [1:NPORT];
  reg  [NPORT:1]  watchOn;

  // Bus slave
  reg             awHeld;
  reg             wHeld;
  reg  [7:0]      awAddr;
  reg  [31:0]     wData;
  reg  [3:0]      wStrb;

  wire            detStart;
  wire            doWrite;
  wire            irqClear;
  wire            typeSet;
  wire [NPORT:1]  dcpActive;
  reg  [NPORT:1]  portOff;
  reg  [NPORT:1]  next_portPower;
  reg  [2:0]      next_type;
  integer         i;

  function mapped;
    input [7:0] a;
    begin
      mapped = (a == `BCPM_OFS_CTRL) || (a == `BCPM_OFS_CHGEN) ||
               (a == `BCPM_OFS_CHGSTAT) || (a == `BCPM_OFS_PORTSTAT);
    end
  endfunction

  // Detection start from either stage entry
  assign detStart = ~upstreamHsic & (detState == DET_IDLE) & ctrl[`BCPM_CTRL_DETEN] &
                    ((chargerDetectStage & ~prevDetStage) |
                     (ctrl[`BCPM_CTRL_OSCDET] & waitReferenceClockStage &
                      ~prevWaitStage));

  // Charger classification from observed line states
  always @* begin
    if (dpDmShorted)
      next_type = `BCPM_TYPE_DCP;
    else if (ctrl[`BCPM_CTRL_ENHANCED] && dmReflectsDp)
      next_type = `BCPM_TYPE_CDP;
    else if (dpLevel == `BCPM_LVL_2V7 && dmLevel == `BCPM_LVL_2V0)
      next_type = `BCPM_TYPE_SUPER;
    else if (dpLevel == `BCPM_LVL_2V0 && dmLevel == `BCPM_LVL_2V0)
      next_type = `BCPM_TYPE_LOW;
    else if (dpLevel == `BCPM_LVL_2V0 && dmLevel == `BCPM_LVL_2V7)
      next_type = `BCPM_TYPE_HIGH;
    else if (bothPulledDown)
      next_type = `BCPM_TYPE_SDP;
    else
      next_type = `BCPM_TYPE_NONE;
  end

  assign typeSet  = (detState == DET_CLASS) && (next_type != `BCPM_TYPE_NONE);
  assign doWrite  = awHeld & wHeld & ~s_axi_bvalid;
  assign irqClear = doWrite && (awAddr == `BCPM_OFS_CHGSTAT) && wStrb[0] &&
                    wData[`BCPM_STAT_IRQ];

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      detState      <= DET_IDLE;
      detTimer      <= {TW{1'b0}};
      prevDetStage  <= 1'b0;
      prevWaitStage <= 1'b0;
      chgType       <= `BCPM_TYPE_NONE;
      typeValid     <= 1'b0;
      chargerIrq    <= 1'b0;
      detectBusy    <= 1'b0;
    end else if (clkEn) begin
      prevDetStage  <= chargerDetectStage;
      prevWaitStage <= waitReferenceClockStage;
      case (detState)
        DET_IDLE: begin
          if (detStart) begin
            detState   <= DET_SETTLE;
            detTimer   <= SETTLE_CYCLES;
            detectBusy <= 1'b1;
          end
        end
        DET_SETTLE: begin
          if (detTimer <= {{(TW-1){1'b0}}, 1'b1})
            detState <= DET_CLASS;
          else
            detTimer <= detTimer - {{(TW-1){1'b0}}, 1'b1};
        end
        DET_CLASS: begin
          detState   <= DET_IDLE;
          detectBusy <= 1'b0;
          chgType    <= next_type;
          typeValid  <= typeSet;
        end
        default: detState <= DET_IDLE;
      endcase
      // A new result outranks a clear in the same cycle
      if (typeSet)
        chargerIrq <= 1'b1;
      else if (irqClear)
        chargerIrq <= 1'b0;
    end
  end

  // Strap sample after reset release
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      strapDone   <= 1'b0;
      smbusEnable <= 1'b0;
    end else if (clkEn && !strapDone) begin
      strapDone   <= 1'b1;
      smbusEnable <= smbusDataLine & smbusClockLine;
    end
  end

  // Classification latched once at init; later enable writes do not move it
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      chgClass    <= {NPORT{1'b0}};
      classFrozen <= 1'b0;
    end else if (clkEn && hwInitDone && !classFrozen) begin
      classFrozen <= 1'b1;
      chgClass    <= chgEnable & ~downstreamHsic;
    end
  end

  assign dcpActive = hostConnected ? {NPORT{1'b0}} : chgClass;

  // Retry schedule, only for ports in dedicated charging mode
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      watchOn <= {NPORT{1'b0}};
      for (i = 1; i <= NPORT; i = i + 1) begin
        ocState[i]  <= OC_ON;
        ocTimer[i]  <= {TW{1'b0}};
        retryCnt[i] <= 2'd0;
      end
    end else if (clkEn) begin
      for (i = 1; i <= NPORT; i = i + 1) begin
        if (!dcpActive[i] || !classFrozen) begin
          ocState[i]  <= OC_ON;
          retryCnt[i] <= 2'd0;
          watchOn[i]  <= 1'b0;
        end else if (ocState[i] == OC_ON) begin
          if (overcurrentSense[i]) begin
            ocState[i] <= OC_OFF;
            watchOn[i] <= 1'b0;
            if (retryCnt[i] < MAXRETRY) begin
              ocTimer[i]  <= SHORT_CYCLES;
              retryCnt[i] <= retryCnt[i] + 2'd1;
            end else begin
              ocTimer[i]  <= LONG_CYCLES;
            end
          end else if (watchOn[i]) begin
            if (ocTimer[i] <= {{(TW-1){1'b0}}, 1'b1}) begin
              watchOn[i]  <= 1'b0;
              retryCnt[i] <= 2'd0;
            end else
              ocTimer[i] <= ocTimer[i] - {{(TW-1){1'b0}}, 1'b1};
          end
        end else begin
          if (ocTimer[i] <= {{(TW-1){1'b0}}, 1'b1}) begin
            ocState[i] <= OC_ON;
            watchOn[i] <= 1'b1;
            ocTimer[i] <= SHORT_CYCLES;
          end else
            ocTimer[i] <= ocTimer[i] - {{(TW-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  // Power selection; host-owned ports follow the host request
  always @* begin
    for (i = 1; i <= NPORT; i = i + 1)
      portOff[i] = dcpActive[i] ? (ocState[i] == OC_OFF) : overcurrentSense[i];
    for (i = 1; i <= NPORT; i = i + 1) begin
      if (!classFrozen)
        next_portPower[i] = 1'b0;
      else if (ctrl[`BCPM_CTRL_GANGED] && (|portOff))
        next_portPower[i] = 1'b0;
      else if (portOff[i])
        next_portPower[i] = 1'b0;
      else if (dcpActive[i])
        next_portPower[i] = 1'b1;
      else
        next_portPower[i] = hostPortPowerReq[i];
    end
  end

  always @(posedge mclk or posedge reset) begin
    if (reset)
      portPowerOut <= {NPORT{1'b0}};
    else if (clkEn)
      portPowerOut <= next_portPower;
  end

  // AXI4-Lite slave; readies fall with clkEn so nothing is taken while frozen
  assign s_axi_awready = clkEn & ~awHeld & ~s_axi_bvalid;
  assign s_axi_wready  = clkEn & ~wHeld & ~s_axi_bvalid;
  assign s_axi_arready = clkEn & ~s_axi_rvalid;

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      awHeld       <= 1'b0;
      wHeld        <= 1'b0;
      awAddr       <= 8'h00;
      wData        <= 32'h0000_0000;
      wStrb        <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OK;
      ctrl         <= `BCPM_CTRL_RESET;
      chgEnable    <= `BCPM_CHGEN_RESET;
    end else if (clkEn) begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld       <= 1'b0;
        wHeld        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(awAddr) ? RESP_OK : RESP_ERR;
        if (awAddr == `BCPM_OFS_CTRL && wStrb[0])
          ctrl <= wData[3:0];
        if (awAddr == `BCPM_OFS_CHGEN && wStrb[0])
          chgEnable <= wData[NPORT:1];
      end else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OK;
    end else if (clkEn) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= mapped(s_axi_araddr) ? RESP_OK : RESP_ERR;
        case (s_axi_araddr)
          `BCPM_OFS_CTRL:     s_axi_rdata <= {28'h0000000, ctrl};
          `BCPM_OFS_CHGEN:    s_axi_rdata <= {27'h0000000, chgEnable, 1'b0};
          `BCPM_OFS_CHGSTAT:  s_axi_rdata <= {25'h0000000, smbusEnable, detectBusy,
                                              chargerIrq, typeValid, chgType};
          `BCPM_OFS_PORTSTAT: s_axi_rdata <= {18'h00000, classFrozen, dcpActive,
                                              chgClass, portPowerOut, 1'b0};
          default:            s_axi_rdata <= 32'h0000_0000;
        endcase
      end else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule // bcpm_top

// File: tb/bcpm_props.sv
// Concurrent checks on the charge port manager top ports.
// Assumes clkEn is held high by the bench.
`timescale 1ns/1ps
module bcpm_props #(
  parameter NPORT         = 4,
  parameter SETTLE_CYCLES = 3
) (
  // Clock and reset
  input wire             mclk,
  input wire             reset,
  // Register bus handshakes
  input wire             s_axi_awready,
  input wire             s_axi_wready,
  input wire             s_axi_bvalid,
  input wire             s_axi_bready,
  input wire             s_axi_arready,
  input wire             s_axi_rvalid,
  input wire             s_axi_rready,
  input wire [31:0]      s_axi_rdata,
  // Detection, power, management bus
  input wire             upstreamHsic,
  input wire             detectBusy,
  input wire             chargerIrq,
  input wire [NPORT:1]   overcurrentSense,
  input wire [NPORT:1]   portPowerOut,
  input wire             smbusEnable,
  input wire             smbusDataLine,
  input wire             smbusClockLine
);
  logic [7:0]     busyCnt;
  logic [NPORT:1] ocPrev;
  logic           seen;
  wire  [NPORT:1] ocRise  = overcurrentSense & ~ocPrev;
  wire            smbPull = smbusDataLine & smbusClockLine;
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      busyCnt <= 8'h00;
      ocPrev <= '0;
      seen <= 1'h0;
    end else begin
      busyCnt <= detectBusy ? busyCnt + 8'h01 : 8'h00;
      ocPrev <= overcurrentSense;
      seen <= 1'h1;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  sequence s_detDone; $fell(detectBusy); endsequence
  property p_bHold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_bHold: assert property (p_bHold) else $error("write answer dropped");
  property p_rHold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rHold: assert property (p_rHold) else $error("read answer changed");
  property p_wBlock; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_wBlock: assert property (p_wBlock) else $error("write taken while answering");
  property p_rBlock; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_rBlock: assert property (p_rBlock) else $error("read taken while answering");
  property p_hsic; upstreamHsic && !detectBusy |=> !detectBusy; endproperty
  a_hsic: assert property (p_hsic) else $error("detection on link port");
  // Busy spans the settle count plus the classify cycle
  property p_settle; s_detDone |-> busyCnt == SETTLE_CYCLES + 1; endproperty
  a_settle: assert property (p_settle) else $error("detection length wrong");
  property p_irq; $rose(chargerIrq) |-> s_detDone; endproperty
  a_irq: assert property (p_irq) else $error("irq without result");
  // Retry state flops one cycle ahead of the power flop on dedicated ports
  property p_ocOff; |ocRise |=> ##1 (portPowerOut & $past(ocRise, 2)) == '0; endproperty
  a_ocOff: assert property (p_ocOff) else $error("power kept on fault");
  property p_smbCap; !seen |=> smbusEnable == $past(smbPull); endproperty
  a_smbCap: assert property (p_smbCap) else $error("bus enable capture wrong");
  property p_smbHold; seen |=> $stable(smbusEnable); endproperty
  a_smbHold: assert property (p_smbHold) else $error("bus enable moved");
endmodule // bcpm_props

// File: tb/bcpm_switch_model.sv
// Power switches and attached loads on the downstream ports.
// Assumes the bench raises fault to model a shorted load.
`timescale 1ns/1ps
module bcpm_switch_model #(
  parameter NPORT = 4
) (
  // Clock
  input  wire             mclk,
  // Switch enables and bench command
  input  wire [NPORT:1]   portPowerOut,
  input  wire [NPORT:1]   fault,
  // Flag back to the hub
  output logic [NPORT:1]  overcurrentSense
);
  // Flag trips only while the switch is on, as a current limiter does
  initial overcurrentSense = '0;
  always @(posedge mclk) overcurrentSense <= fault & portPowerOut;
endmodule // bcpm_switch_model

// File: tb/tb_top.sv
// Self-checking bench for the charge port manager with a switch model.
// Assumes short timing parameters so retries fit a short run.
`timescale 1ns/1ps
`include "bcpm_consts.vh"
module tb_top;
  localparam int S = 20;
  localparam int L = 60;
  localparam int T = 3;
  logic        mclk = 1'h0, reset = 1'h1, clkEn = 1'h1;
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic        s_axi_arvalid = '0, s_axi_rready = '0;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  logic        chargerDetectStage = '0, waitReferenceClockStage = '0, hwInitDone = '0;
  logic        upstreamHsic = '0, hostConnected = '0, dpDmShorted = '0, dmReflectsDp = '0;
  logic        bothPulledDown = '0, smbusDataLine = 1'h1, smbusClockLine = 1'h1;
  logic [1:0]  dpLevel = '0, dmLevel = '0;
  logic [4:1]  downstreamHsic = '0, hostPortPowerReq = '0, fault = '0;
  wire  [4:1]  overcurrentSense, portPowerOut;
  wire         chargerIrq, detectBusy, smbusEnable;
  int          num_errors = 0, checked = 0;

  bcpm_top #(.SHORT_CYCLES(S[27:0]), .LONG_CYCLES(L[27:0]), .SETTLE_CYCLES(T[27:0])) DUT (
    .mclk, .reset, .clkEn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .chargerDetectStage, .waitReferenceClockStage,
    .hwInitDone, .upstreamHsic, .downstreamHsic, .hostConnected, .dpDmShorted,
    .dmReflectsDp, .bothPulledDown, .dpLevel, .dmLevel, .hostPortPowerReq,
    .overcurrentSense, .portPowerOut, .chargerIrq, .detectBusy, .smbusEnable,
    .smbusDataLine, .smbusClockLine);
  bcpm_switch_model PSW (.mclk, .portPowerOut, .fault, .overcurrentSense);

  initial forever #20 mclk = ~mclk;

  task automatic complete_run();
    if (num_errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t %s got %0h exp %0h", $time, msg, got, exp);
    end
  endtask

  // Readies are sampled on the falling edge, where no input is moving
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic tA, tW, dA, dW;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    dA = 1'h0;
    dW = 1'h0;
    while (!(dA && dW)) begin
      @(negedge mclk);
      tA = s_axi_awvalid && s_axi_awready;
      tW = s_axi_wvalid && s_axi_wready;
      @(posedge mclk);
      if (tA) s_axi_awvalid <= 1'h0;
      if (tW) s_axi_wvalid <= 1'h0;
      dA = dA | tA;
      dW = dW | tW;
    end
    do @(negedge mclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    @(posedge mclk);
    s_axi_bready <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q, output logic [1:0] r);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(negedge mclk); while (!s_axi_arready);
    @(posedge mclk);
    s_axi_arvalid <= 1'h0;
    do @(negedge mclk); while (!s_axi_rvalid);
    q = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge mclk);
    s_axi_rready <= 1'h0;
  endtask

  function automatic int expType(logic sh, logic rf, logic en, logic pd, logic [1:0] dp,
                                 logic [1:0] dm);
    if (sh) return `BCPM_TYPE_DCP;
    if (rf && en) return `BCPM_TYPE_CDP;
    if (dp == `BCPM_LVL_2V7 && dm == `BCPM_LVL_2V0) return `BCPM_TYPE_SUPER;
    if (dp == `BCPM_LVL_2V0 && dm == `BCPM_LVL_2V0) return `BCPM_TYPE_LOW;
    if (dp == `BCPM_LVL_2V0 && dm == `BCPM_LVL_2V7) return `BCPM_TYPE_HIGH;
    if (pd) return `BCPM_TYPE_SDP;
    return `BCPM_TYPE_NONE;
  endfunction

  // A negative expected type means the start must be ignored
  task automatic det(input logic viaWait, input int expT);
    int n;
    logic [31:0] q;
    logic [1:0] r;
    @(posedge mclk);
    if (viaWait) waitReferenceClockStage <= 1'h1;
    else chargerDetectStage <= 1'h1;
    n = 0;
    do begin @(negedge mclk); n++; end while (!detectBusy && n < 4);
    if (expT < 0) chk(detectBusy, 1'h0, "start");
    else begin
      chk(detectBusy, 1'h1, "start");
      while (detectBusy && n < 30) begin @(negedge mclk); n++; end
      rd(`BCPM_OFS_CHGSTAT, q, r);
      chk(q[2:0], expT[2:0], "type");
      chk({chargerIrq, q[4]}, {2{expT != 0}}, "irq");
      wr(`BCPM_OFS_CHGSTAT, 32'h10, r);
      chk(chargerIrq, 1'h0, "irq clear");
    end
    @(posedge mclk);
    chargerDetectStage <= 1'h0;
    waitReferenceClockStage <= 1'h0;
  endtask

  // Also returns all port enables at the first cycle port 1 is off
  task automatic offLen(output int n, output logic [4:1] o);
    n = 0;
    while (portPowerOut[1] && n < 200) begin @(negedge mclk); n++; end
    o = portPowerOut;
    n = 0;
    while (!portPowerOut[1] && n < 200) begin @(negedge mclk); n++; end
  endtask

  initial begin
    int k, n, e;
    logic [31:0] q, t;
    logic [1:0] r;
    logic [6:0] v;
    logic [6:0] tbl [6];
    logic [4:1] pw;
    tbl = '{7'h40, 7'h20, 7'h10, 7'h05, 7'h06, 7'h09};
    void'($urandom(21680));
    repeat (5) @(posedge mclk);
    reset <= 1'h0;
    rd(`BCPM_OFS_CHGSTAT, q, r);
    chk({smbusEnable, q[6]}, 2'h3, "bus on");
    rd(`BCPM_OFS_CTRL, q, r);
    chk(q, 32'h0, "ctrl reset");
    rd(`BCPM_OFS_CHGEN, q, r);
    chk(q, 32'h0, "chgen reset");
    rd(8'h10, q, r);
    chk(r, 2'h2, "unmapped rd");
    wr(8'h14, 32'hF, r);
    chk(r, 2'h2, "unmapped wr");
    // Directed profiles first, then random line levels within 0..2
    for (k = 0; k < 10; k++) begin
      t = $urandom;
      v = (k < 6) ? tbl[k] : t[6:0];
      if (v[3:2] == 2'h3) v[3:2] = 2'h0;
      if (v[1:0] == 2'h3) v[1:0] = 2'h0;
      wr(`BCPM_OFS_CTRL, {30'h0, k < 6 || t[7], 1'h1}, r);
      {dpDmShorted, dmReflectsDp, bothPulledDown, dpLevel, dmLevel} <= v;
      det(1'h0, expType(v[6], v[5], k < 6 || t[7], v[4], v[3:2], v[1:0]));
    end
    wr(`BCPM_OFS_CTRL, 32'h5, r);
    det(1'h1, expType(v[6], v[5], 1'h0, v[4], v[3:2], v[1:0]));
    upstreamHsic <= 1'h1;
    det(1'h0, -1);
    upstreamHsic <= 1'h0;
    t = $urandom;
    hostPortPowerReq <= t[3:0];
    downstreamHsic <= 4'h4;
    wr(`BCPM_OFS_CHGEN, 32'hE, r);
    wr(`BCPM_OFS_CTRL, 32'h0, r);
    chk(portPowerOut[2:1], 2'h0, "before init");
    hwInitDone <= 1'h1;
    repeat (3) @(negedge mclk);
    chk(portPowerOut, {t[3:2], 2'h3}, "init power");
    rd(`BCPM_OFS_PORTSTAT, q, r);
    chk(q[12:5], 8'h33, "class");
    wr(`BCPM_OFS_CHGEN, 32'h0, r);
    rd(`BCPM_OFS_PORTSTAT, q, r);
    chk(q[12:5], 8'h33, "frozen");
    fault <= 4'h1;
    for (k = 0; k < 5; k++) begin
      offLen(n, pw);
      e = (k < 3) ? S : L;
      chk(n >= e && n <= e + 2, 1'h1, "off time");
      if (k == 0) chk(pw[2], 1'h1, "neighbour");
    end
    @(posedge mclk);
    fault <= 4'h0;
    repeat (L + S + 10) @(posedge mclk);
    fault <= 4'h1;
    offLen(n, pw);
    chk(n >= S && n <= S + 2, 1'h1, "count cleared");
    @(posedge mclk);
    fault <= 4'h0;
    repeat (2 * S + 10) @(posedge mclk);
    wr(`BCPM_OFS_CTRL, 32'h8, r);
    fault <= 4'h1;
    repeat (4) @(negedge mclk);
    chk(portPowerOut[2:1], 2'h0, "ganged");
    @(posedge mclk);
    fault <= 4'h0;
    hostConnected <= 1'h1;
    hostPortPowerReq <= 4'hF;
    repeat (2 * S + 10) @(negedge mclk);
    chk(portPowerOut, 4'hF, "host power");
    @(posedge mclk);
    fault <= 4'h1;
    offLen(n, pw);
    chk(n <= 3, 1'h1, "no local hold");
    @(posedge mclk);
    fault <= 4'h0;
    smbusDataLine <= 1'h0;
    reset <= 1'h1;
    repeat (5) @(posedge mclk);
    reset <= 1'h0;
    repeat (2) @(negedge mclk);
    chk(smbusEnable, 1'h0, "bus off");
    complete_run();
  end

  // Whole run needs well under 3000 cycles
  initial begin
    repeat (6000) @(posedge mclk);
    num_errors++;
    complete_run();
  end
endmodule // tb_top

bind bcpm_top bcpm_props #(.NPORT(NPORT), .SETTLE_CYCLES(SETTLE_CYCLES)) u_props (
  .mclk, .reset, .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .upstreamHsic, .detectBusy,
  .chargerIrq, .overcurrentSense, .portPowerOut, .smbusEnable, .smbusDataLine,
  .smbusClockLine);
